// ### design/char_skid_buffer.sv
/*
  two-entry buffer with valid and ready on both sides; outputs come from
  the head register. assumes both sides run on the same clock.
*/
`timescale 1ns/10ps
module char_skid_buffer #(
  parameter int WIDTH = 15
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic spare_valid_r;
  logic [WIDTH-1:0] spare_r;
  logic push;
  logic pop;

  // handshakes, ready only while the spare slot is free
  assign in_ready = !spare_valid_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // head refills from the spare first so order is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
      spare_valid_r <= 1'b0;
      spare_r <= '0;
    end else if (!out_valid || pop) begin
      if (spare_valid_r) begin
        out_valid <= 1'b1;
        out_data <= spare_r;
        spare_valid_r <= 1'b0;
      end else begin
        out_valid <= push;
        if (push) out_data <= in_data;
      end
    end else if (push) begin
      spare_valid_r <= 1'b1;
      spare_r <= in_data;
    end
  end

  // a stalled head word must not change
  hold_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer head changed while stalled");
endmodule

// ### design/tx_parallel_input_select.sv
/*
  transmit parallel input selector: maps the host transmit bus onto
  characters for the encoder, with an internal transmit queue, pause and
  stop handling, idle fill and an apb register port.
  assumes pclk is the transmit clock in queue mode and the reference clock
  in bypass mode; host pins are asynchronous and synchronised here.
*/
// Chosen here: the address map and the APB register port.
`timescale 1ns/10ps
import txsel_pkg::*;

// What this block does
// - encoder bypassed: bit 9 line is always the tenth character bit.
// - queue bypassed, encoder on: the pause/bit 9 line is ignored.
// - queue bypassed, encoder on, violation flag: drop the word, send c0.7.
// - encoder bypassed, 12-bit width: bit 10 line is the eleventh bit.
// - encoder bypassed, 8-bit width: bit 10 and bit 11 lines ignored.
// - queue and encoder on: cell start marks a packet's first character.
// - queue bypassed, encoder on: the cell start/bit 11 line is ignored.
// - 12-bit raw mode: bit 11 line is the character's top bit.
// - queue and encoder on: violation, cell start, special select decode together.
// - queue bypassed, encoder on: special select picks data or control.
// - encoder bypassed: special select input is ignored.
// - write enable high active in cascade timing, low active otherwise.
// - queue on and write enabled: load the bus every clock edge while the queue is not full.
// - no write, pause or stop: drain the queue, then send c5.0 idles.
// - pause asserted: send idles, keep accepting writes, resume after release.
// - queue bypassed: send the bus while enabled, c5.0 otherwise.
module tx_parallel_input_select #(
  parameter int DEPTH = 256,
  parameter logic [TBL_W*8-1:0] DECODE_TABLE = txsel_pkg::FLAG_TABLE
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host transmit pins
  input wire logic [7:0] transmit_word,
  input wire logic transmit_bit8,
  input wire logic transmit_pause_n,
  input wire logic send_violation_flag,
  input wire logic cell_start_flag,
  input wire logic special_or_data_select,
  input wire logic transmit_write_enable,
  input wire logic cell_stop_request_n,
  // characters toward the encoder
  output logic char_valid,
  output logic [11:0] char_code,
  output txsel_pkg::char_kind_e char_kind,
  output logic char_frame_start,
  input wire logic char_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [PIN_W-1:0] pins_s1_r;
  logic [PIN_W-1:0] pins_s2_r;
  logic [CFG_W-1:0] config_r;
  logic overflow_r;
  logic [11:0] queue_mem [DEPTH];
  logic [DEPTH-1:0] queue_scd_r;
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic armed_r;
  logic held_r;

  // table lookup, used for the queue path
  function automatic logic [TBL_W-1:0] table_entry(input logic [2:0] idx);
    table_entry = DECODE_TABLE[idx*TBL_W +: TBL_W];
  endfunction

  // raw character assembly shared by both paths
  function automatic logic [11:0] raw_char(input logic [11:0] w, input logic width8);
    raw_char = width8 ? {2'b00, w[9:0]} : w;
  endfunction

  // host pins pass two flip-flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_s1_r <= PIN_RST;
      pins_s2_r <= PIN_RST;
    end else begin
      pins_s1_r <= {cell_stop_request_n, transmit_write_enable, special_or_data_select,
                    cell_start_flag, send_violation_flag, transmit_pause_n,
                    transmit_bit8, transmit_word};
      pins_s2_r <= pins_s1_r;
    end
  end

  // configuration decode
  wire enc_on = config_r[CFG_ENC_BIT];
  wire queue_on = config_r[CFG_QUEUE_BIT];
  wire width8 = config_r[CFG_WIDTH_BIT];
  wire cascade = config_r[CFG_CASCADE_BIT];
  wire [11:0] pin_word = pins_s2_r[11:0];
  wire pin_scd = pins_s2_r[PIN_SCD];
  wire we_act = cascade ? pins_s2_r[PIN_WE] : !pins_s2_r[PIN_WE];
  wire stop_act = !pins_s2_r[PIN_STOP];

  // queue state
  wire q_empty = (count_r == '0);
  wire q_full = (count_r == (AW+1)'(DEPTH));
  wire [11:0] head = queue_mem[rd_ptr_r];
  wire head_scd = queue_scd_r[rd_ptr_r];
  wire head_soc = head[PIN_B11];
  wire buf_ready;

  // pause line is data when the encoder is bypassed; stop then acts as pause
  function automatic logic head_pause_n();
    head_pause_n = pins_s2_r[PIN_B9];
  endfunction
  wire pause_act = enc_on ? !head_pause_n() : stop_act;
  wire soc_block = enc_on && stop_act && head_soc && !armed_r;
  wire q_wr = queue_on && we_act && !q_full;
  wire q_rd = queue_on && buf_ready && !q_empty && !pause_act && !soc_block;

  // queue path: table for encoded, raw for bypassed, idle when nothing read
  wire [TBL_W-1:0] tbl = table_entry({head_scd, head[PIN_B10], head_soc});
  wire [11:0] q_tbl_code = tbl[8] ? {4'h0, tbl[7:0]} : {4'h0, head[7:0]};
  wire [11:0] q_code = !q_rd ? {4'h0, IDLE_CODE} :
                       enc_on ? q_tbl_code : raw_char(head, width8);
  wire [1:0] q_kind = !q_rd ? KIND_SPECIAL : enc_on ? tbl[10:9] : KIND_RAW;
  wire q_frame = q_rd && enc_on && head_soc;

  // bypass path: bits 9 and 11 unused with the encoder on
  wire [11:0] b_enc_code = pins_s2_r[PIN_B10] ? {4'h0, VIOL_CODE} :
                           {4'h0, pin_word[7:0]};
  wire [1:0] b_enc_kind = (pins_s2_r[PIN_B10] || pin_scd) ? KIND_SPECIAL : KIND_DATA;
  wire [11:0] b_code = !we_act ? {4'h0, IDLE_CODE} :
                       enc_on ? b_enc_code : raw_char(pin_word, width8);
  wire [1:0] b_kind = !we_act ? KIND_SPECIAL : enc_on ? b_enc_kind : KIND_RAW;

  // one character offered to the buffer every cycle
  wire [BUF_W-1:0] buf_in = queue_on ? {q_frame, q_kind, q_code} : {1'b0, b_kind, b_code};
  wire [BUF_W-1:0] buf_out;
  wire [1:0] kind_bits;

  char_skid_buffer #(
    .WIDTH(BUF_W)
  ) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(1'b1),
    .in_data(buf_in),
    .in_ready(buf_ready),
    .out_valid(char_valid),
    .out_data(buf_out),
    .out_ready(char_ready)
  );
  assign char_frame_start = buf_out[14];
  assign kind_bits = buf_out[13:12];
  assign char_kind = char_kind_e'(kind_bits);
  assign char_code = buf_out[11:0];

  // queue storage, no reset on the array
  always_ff @(posedge pclk) begin
    if (q_wr) queue_mem[wr_ptr_r] <= pin_word;
  end

  // queue pointers, level, special select column
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      queue_scd_r <= '0;
    end else begin
      if (q_wr) wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      if (q_wr) queue_scd_r[wr_ptr_r] <= pin_scd;
      if (q_rd) rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(q_wr) - (AW+1)'(q_rd);
    end
  end

  // stop on cell start: one more cell after stop is released and reasserted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      if (soc_block) held_r <= 1'b1;
      else if (armed_r) held_r <= 1'b0;
      if (!stop_act && held_r) armed_r <= 1'b1;
      else if (q_rd && stop_act && head_soc) armed_r <= 1'b0;
    end
  end

  // apb decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire hit_cfg = (paddr == CONFIG_OFS);
  wire hit_stat = (paddr == STATUS_OFS);
  wire ovf_set = queue_on && we_act && q_full;
  wire ovf_clr = access && pwrite && hit_stat && pwdata[STAT_OVF_BIT];
  wire [31:0] stat_word = {13'h0000, overflow_r, q_full, q_empty, 7'h00, count_r};
  wire [31:0] rd_word = hit_cfg ? {28'h0000000, config_r} : hit_stat ? stat_word : 32'h00000000;

  // apb answers one cycle after setup; overflow set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      config_r <= CONFIG_RST;
      overflow_r <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit_cfg && !hit_stat;
      if (setup && !pwrite) prdata <= rd_word;
      if (access && pwrite && hit_cfg) config_r <= pwdata[CFG_W-1:0];
      if (ovf_set) overflow_r <= 1'b1;
      else if (ovf_clr) overflow_r <= 1'b0;
    end
  end

  // checks
  queue_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    q_wr && !q_rd |=> count_r == $past(count_r) + 1'b1)
    else $error("enabled write did not load the queue");
  pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    queue_on && enc_on && !pins_s2_r[PIN_B9] |-> !q_rd)
    else $error("queue read while paused");
  idle_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
    queue_on && q_empty && buf_ready && !char_valid |=>
    char_valid && char_kind == KIND_SPECIAL && char_code == {4'h0, IDLE_CODE})
    else $error("empty queue did not send idle");
  viol_send_a: assert property (@(posedge pclk) disable iff (!presetn)
    !queue_on && enc_on && we_act && pins_s2_r[PIN_B10] |-> buf_in[11:0] == {4'h0, VIOL_CODE})
    else $error("violation request not sent as c0.7");
  narrow_raw_a: assert property (@(posedge pclk) disable iff (!presetn)
    buf_in[13:12] == KIND_RAW && width8 |-> buf_in[11:10] == 2'b00)
    else $error("upper raw bits used in 8-bit mode");
  raw_wide_a: assert property (@(posedge pclk) disable iff (!presetn)
    !queue_on && !enc_on && !width8 && we_act |-> buf_in[11:0] == pin_word)
    else $error("12-bit raw character wrong");
  scd_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    !enc_on && !queue_on && we_act |-> buf_in[13:12] == KIND_RAW)
    else $error("special select used with encoder bypassed");
  bypass_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !queue_on && !we_act |-> buf_in[11:0] == {4'h0, IDLE_CODE} && !q_wr)
    else $error("bypass without enable did not send c5.0");
  polarity_a: assert property (@(posedge pclk) disable iff (!presetn)
    queue_on && !q_full && (cascade != pins_s2_r[PIN_WE]) |-> !q_wr)
    else $error("write enable polarity wrong");
  frame_mark_a: assert property (@(posedge pclk) disable iff (!presetn)
    q_rd && enc_on && head_soc |-> buf_in[14])
    else $error("cell start not marked");
endmodule

// ### design/txsel_pkg.sv
/*
  package for the transmit parallel input selector: register map, field
  positions, reset values, pin vector layout, character kinds and codes.
  assumes nothing beyond a SystemVerilog compiler.
*/
package txsel_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] CONFIG_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  // config fields
  localparam int CFG_ENC_BIT = 0;
  localparam int CFG_QUEUE_BIT = 1;
  localparam int CFG_WIDTH_BIT = 2;
  localparam int CFG_CASCADE_BIT = 3;
  localparam int CFG_W = 4;
  localparam logic [3:0] CONFIG_RST = 4'hF;
  // status fields
  localparam int STAT_EMPTY_BIT = 16;
  localparam int STAT_FULL_BIT = 17;
  localparam int STAT_OVF_BIT = 18;
  // synchronised pin vector layout
  localparam int PIN_B8 = 8;
  localparam int PIN_B9 = 9;
  localparam int PIN_B10 = 10;
  localparam int PIN_B11 = 11;
  localparam int PIN_SCD = 12;
  localparam int PIN_WE = 13;
  localparam int PIN_STOP = 14;
  localparam int PIN_W = 15;
  // pulled-up lines reset high; write enable resets low, idle for the reset cascade timing
  localparam logic [14:0] PIN_RST = 15'h5FFF;
  // kind of character handed to the encoder
  typedef enum logic [1:0] {
    KIND_DATA = 2'b00,
    KIND_SPECIAL = 2'b01,
    KIND_RAW = 2'b10
  } char_kind_e;
  // special codes as byte {y,x} for cx.y
  localparam logic [7:0] IDLE_CODE = 8'h05;
  localparam logic [7:0] VIOL_CODE = 8'hE0;
  // flag decode table, entry {kind[1:0], use_code, code[7:0]}, index {scd,svs,soc}
  localparam int TBL_W = 11;
  localparam logic [87:0] FLAG_TABLE = {
    11'h3E0, 11'h3E0, 11'h200, 11'h200,
    11'h3E0, 11'h3E0, 11'h000, 11'h000
  };
  // buffer word {frame_start, kind[1:0], code[11:0]}
  localparam int BUF_W = 15;
endpackage

// ### tb/host_tx_model.sv
/*
  host transmit logic model: drives the parallel transmit pins for one
  word per cycle while the bench asks for a write.
  assumes the bench changes its requests right after a rising pclk edge.
*/
`timescale 1ns/10ps
module host_tx_model (
  // requests from the bench
  input wire logic cascade,
  input wire logic wr,
  input wire logic [12:0] word,
  input wire logic pause_n,
  input wire logic stop_n,
  // host transmit pins
  output logic [7:0] transmit_word,
  output logic transmit_bit8,
  output logic transmit_pause_n,
  output logic send_violation_flag,
  output logic cell_start_flag,
  output logic special_or_data_select,
  output logic transmit_write_enable,
  output logic cell_stop_request_n
);
  // enable follows the selected timing polarity
  assign transmit_write_enable = wr ? cascade : ~cascade;
  // the bench sets cell start on a packet's first word; idle lines sit at pull-up
  assign {special_or_data_select, cell_start_flag, send_violation_flag} =
    wr ? word[12:10] : 3'b111;
  assign transmit_pause_n = wr ? word[9] : pause_n;
  assign {transmit_bit8, transmit_word} = wr ? word[8:0] : 9'h1FF;
  assign cell_stop_request_n = stop_n;
endmodule

// ### tb/tx_parallel_input_select_tb.sv
/*
  self-checking bench for the transmit parallel input selector.
  assumes the host model drives the pins and the bench plays the encoder.
*/
`timescale 1ns/10ps
module tx_parallel_input_select_tb;
  import txsel_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, char_ready = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, char_valid, char_frame_start;
  logic cascade = 1, wr = 0, pause_n = 1, stop_n = 1;
  logic [12:0] word = 13'h0000;
  logic [7:0] transmit_word;
  logic transmit_bit8, transmit_pause_n, send_violation_flag, cell_start_flag;
  logic special_or_data_select, transmit_write_enable, cell_stop_request_n;
  logic [11:0] char_code;
  char_kind_e char_kind;
  int fail_count = 0, compares = 0;
  wire [31:0] seen = {16'h0, char_valid, char_kind, char_frame_start, char_code};
  wire took = char_valid === 1'b1 && char_ready === 1'b1 && char_code !== {4'h0, IDLE_CODE};

  // 40 MHz clock
  initial forever #12.5 pclk = ~pclk;

  host_tx_model host (.cascade, .wr, .word, .pause_n, .stop_n, .transmit_word,
    .transmit_bit8, .transmit_pause_n, .send_violation_flag, .cell_start_flag,
    .special_or_data_select, .transmit_write_enable, .cell_stop_request_n);
  tx_parallel_input_select dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .transmit_word, .transmit_bit8,
    .transmit_pause_n, .send_violation_flag, .cell_start_flag,
    .special_or_data_select, .transmit_write_enable, .cell_stop_request_n,
    .char_valid, .char_code, .char_kind, .char_frame_start, .char_ready);

  function automatic logic [31:0] ch(input logic [1:0] k, input logic f, input logic [11:0] c);
    return {16'h0, 1'b1, k, f, c};
  endfunction

  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tally_and_finish;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish;
    end
    psel <= 0;
    penable <= 0;
  endtask

  // new settings, then let stray words from the switch drain away
  task cfg(input logic [3:0] v);
    apb(1, CONFIG_OFS, {28'h0, v});
    cascade <= v[3];
    repeat (10) @(posedge pclk);
  endtask

  task send(input logic [12:0] w);
    @(posedge pclk);
    wr <= 1; word <= w;
  endtask

  task quiet;
    @(posedge pclk);
    wr <= 0;
  endtask

  // wait for the next accepted non-idle character and compare it
  task wait_char(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (took !== 1'b1 && n < 60);
    if (took !== 1'b1) begin
      fail_count++;
      tally_and_finish;
    end
    check(seen, exp);
  endtask

  task send1(input logic [12:0] w, input logic [31:0] exp);
    send(w);
    quiet;
    wait_char(exp);
  endtask

  task expect_idle;
    repeat (6) @(posedge pclk);
    check(seen, ch(KIND_SPECIAL, 1'b0, {4'h0, IDLE_CODE}));
  endtask

  task t_reset;
    expect_idle;
    apb(0, CONFIG_OFS, 32'h0);
    check(rd, {28'h0, CONFIG_RST});
    apb(0, STATUS_OFS, 32'h0);
    check({31'h0, rd[STAT_EMPTY_BIT]}, 32'h1);
    apb(0, 8'h08, 32'h0);
    check({er, rd[30:0]}, 32'h80000000);
  endtask

  // four words loaded back to back while the encoder stalls
  task t_queue;
    @(posedge pclk);
    char_ready <= 0;
    send(13'h0A12);
    send(13'h12BC);
    send(13'h0634);
    send(13'h0256);
    quiet;
    repeat (10) @(posedge pclk);
    char_ready <= 1;
    wait_char(ch(KIND_DATA, 1'b1, 12'h012));
    wait_char(ch(KIND_SPECIAL, 1'b0, 12'h0BC));
    wait_char(ch(KIND_SPECIAL, 1'b0, {4'h0, VIOL_CODE}));
    wait_char(ch(KIND_DATA, 1'b0, 12'h056));
    expect_idle;
  endtask

  task t_pause;
    @(posedge pclk);
    pause_n <= 0;
    send(13'h0077);
    quiet;
    repeat (20) begin
      @(posedge pclk);
      check({31'h0, took}, 32'h0);
    end
    apb(0, STATUS_OFS, 32'h0);
    check({23'h0, rd[8:0]}, 32'h1);
    pause_n <= 1;
    wait_char(ch(KIND_DATA, 1'b0, 12'h077));
  endtask

  task t_bypass;
    cfg(4'hD);
    send1(13'h085A, ch(KIND_DATA, 1'b0, 12'h05A));
    send1(13'h0477, ch(KIND_SPECIAL, 1'b0, {4'h0, VIOL_CODE}));
    send1(13'h103C, ch(KIND_SPECIAL, 1'b0, 12'h03C));
    expect_idle;
  endtask

  task t_raw;
    cfg(4'h8);
    send1(13'h1ABC, ch(KIND_RAW, 1'b0, 12'hABC));
    cfg(4'hC);
    send1(13'h1ABC, ch(KIND_RAW, 1'b0, 12'h2BC));
  endtask

  // queue with encoder bypassed: a low bit 9 line is data, not a pause
  task t_raw_queue;
    cfg(4'hA);
    pause_n <= 0;
    send1(13'h0DEF, ch(KIND_RAW, 1'b0, 12'hDEF));
    pause_n <= 1;
  endtask

  task t_utopia;
    cfg(4'h5);
    send1(13'h0066, ch(KIND_DATA, 1'b0, 12'h066));
    expect_idle;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_queue;
    t_pause;
    t_bypass;
    t_raw;
    t_raw_queue;
    t_utopia;
    tally_and_finish;
  end
endmodule
